// [hdl/tmr_timer8.sv]
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
module tmr_timer8 #(
   parameter int SLOW_DIV = tmr_pkg::DIV_SLOW_RATIO
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tmr_pkg::ADDR_W-1:0] paddr,
   input wire logic [tmr_pkg::DATA_W-1:0] pwdata,
   output logic [tmr_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [tmr_pkg::NUM_CH-1:0] ext_clk_in,
   input wire logic [tmr_pkg::NUM_CH-1:0] ext_clear_in,
   input wire logic [tmr_pkg::NUM_CH-1:0] xfer_start_a,
   input wire logic [tmr_pkg::NUM_CH-1:0] xfer_start_b,
   input wire logic [tmr_pkg::NUM_CH-1:0] clear_on_transfer_select_a,
   input wire logic [tmr_pkg::NUM_CH-1:0] clear_on_transfer_select_b,
   output logic [tmr_pkg::NUM_CH-1:0] timer_out,
   output logic [tmr_pkg::NUM_CH-1:0] timer_out_en,
   output logic [tmr_pkg::NUM_CH-1:0] match_a_irq,
   output logic [tmr_pkg::NUM_CH-1:0] match_b_irq,
   output logic [tmr_pkg::NUM_CH-1:0] wrap_irq,
   output logic conv_start,
   output logic timer_halted
);
   import tmr_pkg::*;

   localparam int PRESC_W = $clog2(SLOW_DIV);
   localparam int FAST_BIT = $clog2(DIV_FAST_RATIO) - 1;
   localparam int MID_BIT = $clog2(DIV_MID_RATIO) - 1;
   localparam int SLOW_BIT = PRESC_W - 1;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic acc;
   logic wr_acc;
   logic rd_acc;
   logic setup;
   logic [ADDR_W-1:0] ch_off;
   logic [ADDR_W-1:0] ch_num;
   logic off_ok;
   logic hit_stop;
   logic addr_ok;
   logic [DATA_W-1:0] next_prdata;
   logic [STOP_W-1:0] module_stop_control;
   logic [PRESC_W-1:0] presc;
   logic [NUM_CH-1:0] ch_hit;
   logic [NUM_CH-1:0] match_a_p;
   logic [NUM_CH-1:0] match_b_p;
   logic [NUM_CH-1:0] wrap_p;
   logic [NUM_CH-1:0] casc_q;
   logic [7:0] rd_word [NUM_CH];

   assign acc = psel & penable;
   assign setup = psel & ~penable;
   assign ch_off = paddr & CH_OFS_MASK;
   assign ch_num = paddr >> CH_SHIFT;
   assign hit_stop = (paddr == OFS_STOP);
   assign off_ok = (ch_off == OFS_CTRL) || (ch_off == OFS_STAT) || (ch_off == OFS_CONST_A)
                   || (ch_off == OFS_CONST_B) || (ch_off == OFS_COUNT);
   assign addr_ok = hit_stop || ((ch_num < ADDR_W'(NUM_CH)) && off_ok);
   assign timer_halted = module_stop_control[HALT_BIT];

   // timer registers are closed while halted
   assign wr_acc = acc & pwrite & addr_ok & (hit_stop | ~timer_halted);
   assign rd_acc = acc & ~pwrite & addr_ok & (hit_stop | ~timer_halted);
   assign pready = 1'b1;
   assign pslverr = acc & ~(addr_ok & (hit_stop | ~timer_halted));

   // ----------------------------------------
   // read data, sampled in the setup cycle
   // ----------------------------------------
   always_comb begin
      next_prdata = '0;
      if (hit_stop) begin
         next_prdata[STOP_W-1:0] = module_stop_control;
      end else if (addr_ok && !timer_halted) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (ch_hit[c]) begin
               next_prdata[7:0] = rd_word[c];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (setup) begin
         prdata <= next_prdata;
      end
   end

   // ----------------------------------------
   // module stop register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_stop_control <= STOP_RST;
      end else if (wr_acc && hit_stop) begin
         module_stop_control <= pwdata[STOP_W-1:0];
      end
   end

   // ----------------------------------------
   // shared prescaler
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc <= '0;
      end else if (!timer_halted) begin
         presc <= presc + PRESC_W'(1);
      end
   end

   // ----------------------------------------
   // cascade pulses, one cycle late
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         casc_q <= '0;
      end else begin
         casc_q[0] <= wrap_p[1];
         casc_q[1] <= match_a_p[0];
      end
   end

   // ----------------------------------------
   // channel logic
   // ----------------------------------------
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [7:0] STAT_RST = (c == 0) ? STAT0_RST : STAT1_RST;
      tmr_ctrl_t timer_control;
      tmr_status_t stat;
      logic [7:0] constant_a;
      logic [7:0] constant_b;
      logic [7:0] count_value;
      logic [2:0] arm;
      logic tick;
      logic wr_ctrl;
      logic wr_stat;
      logic wr_ca;
      logic wr_cb;
      logic wr_cnt;
      logic rd_stat;
      logic ext_clr_prev;
      logic ext_clr_rise;
      logic cnt_clr;
      logic clr_sw_b;
      logic clr_sw_a;
      logic clr_sw_w;
      logic clr_xfer_a;
      logic clr_xfer_b;
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [1:0] act;
      logic out_level;

      assign ch_hit[c] = (ch_num == ADDR_W'(c));
      assign wr_ctrl = wr_acc & ch_hit[c] & (ch_off == OFS_CTRL);
      assign wr_stat = wr_acc & ch_hit[c] & (ch_off == OFS_STAT);
      assign wr_ca = wr_acc & ch_hit[c] & (ch_off == OFS_CONST_A);
      assign wr_cb = wr_acc & ch_hit[c] & (ch_off == OFS_CONST_B);
      assign wr_cnt = wr_acc & ch_hit[c] & (ch_off == OFS_COUNT);
      assign rd_stat = rd_acc & ch_hit[c] & (ch_off == OFS_STAT);

      always_comb begin
         unique case (ch_off)
            OFS_CTRL: rd_word[c] = timer_control;
            OFS_STAT: rd_word[c] = stat;
            OFS_CONST_A: rd_word[c] = constant_a;
            OFS_CONST_B: rd_word[c] = constant_b;
            default: rd_word[c] = count_value;
         endcase
      end

      tmr_tick #(
         .PRESC_W(PRESC_W),
         .FAST_BIT(FAST_BIT),
         .MID_BIT(MID_BIT),
         .SLOW_BIT(SLOW_BIT)
      ) u_tick (
         .pclk(pclk),
         .presetn(presetn),
         .run(~timer_halted),
         .clk_sel(timer_control.clk_sel),
         .presc(presc),
         .ext_clk(ext_clk_in[c]),
         .casc_pulse(casc_q[c]),
         .tick(tick)
      );

      // compare acts at the count clock after equality; skipped on a constant write
      assign match_a_p[c] = tick & (count_value == constant_a) & ~wr_ca;
      assign match_b_p[c] = tick & (count_value == constant_b) & ~wr_cb;
      assign ext_clr_rise = ext_clear_in[c] & ~ext_clr_prev;

      always_comb begin
         unique case (timer_control.clear_sel)
            CLR_MATCH_A: cnt_clr = match_a_p[c];
            CLR_MATCH_B: cnt_clr = match_b_p[c];
            CLR_EXT: cnt_clr = ext_clr_rise;
            default: cnt_clr = 1'b0;
         endcase
      end

      assign wrap_p[c] = tick & (count_value == COUNT_MAX) & ~cnt_clr & ~wr_cnt;

      // ---- control and constant registers ----
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            timer_control <= CTRL_RST;
            constant_a <= CONST_RST;
            constant_b <= CONST_RST;
            ext_clr_prev <= 1'b0;
         end else begin
            ext_clr_prev <= ext_clear_in[c];
            if (wr_ctrl) begin
               timer_control <= pwdata[7:0];
            end
            if (wr_ca) begin
               constant_a <= pwdata[7:0];
            end
            if (wr_cb) begin
               constant_b <= pwdata[7:0];
            end
         end
      end

      // ---- counter: clear over write over increment ----
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            count_value <= COUNT_RST;
         end else if (cnt_clr) begin
            count_value <= COUNT_RST;
         end else if (wr_cnt) begin
            count_value <= pwdata[7:0];
         end else if (tick) begin
            count_value <= count_value + 8'h01;
         end
      end

      // ---- read-1 arming for software flag clears, not transfer clears ----
      assign clr_sw_b = wr_stat & ~pwdata[FLAG_B_BIT] & arm[2];
      assign clr_sw_a = wr_stat & ~pwdata[FLAG_A_BIT] & arm[1];
      assign clr_sw_w = wr_stat & ~pwdata[WRAP_BIT] & arm[0];
      assign clr_xfer_b = xfer_start_b[c] & ~clear_on_transfer_select_b[c];
      assign clr_xfer_a = xfer_start_a[c] & ~clear_on_transfer_select_a[c];

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            arm <= 3'h0;
         end else if (rd_stat) begin
            arm <= {prdata[FLAG_B_BIT], prdata[FLAG_A_BIT], prdata[WRAP_BIT]};
         end else begin
            arm <= arm & ~{clr_sw_b | clr_xfer_b, clr_sw_a | clr_xfer_a, clr_sw_w};
         end
      end

      // ---- status flags: a set wins over a clear ----
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            stat <= STAT_RST;
         end else begin
            stat.match_b_flag <= match_b_p[c] | (stat.match_b_flag & ~clr_sw_b & ~clr_xfer_b);
            stat.match_a_flag <= match_a_p[c] | (stat.match_a_flag & ~clr_sw_a & ~clr_xfer_a);
            stat.wrap_flag <= wrap_p[c] | (stat.wrap_flag & ~clr_sw_w);
            if (wr_stat) begin
               stat.out_sel_b <= pwdata[3:2];
               stat.out_sel_a <= pwdata[1:0];
               if (c == 0) begin
                  stat.conv_trigger_enable <= pwdata[RSV_BIT];
               end
            end
         end
      end

      // ---- output level ----
      assign act_a = match_a_p[c] ? stat.out_sel_a : OUT_KEEP;
      assign act_b = match_b_p[c] ? stat.out_sel_b : OUT_KEEP;
      // action codes rank as their value: toggle > high > low > keep
      assign act = (act_a > act_b) ? act_a : act_b;

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            out_level <= 1'b0;
         end else begin
            unique case (act)
               OUT_LOW: out_level <= 1'b0;
               OUT_HIGH: out_level <= 1'b1;
               OUT_TOGGLE: out_level <= ~out_level;
               OUT_KEEP: out_level <= out_level;
            endcase
         end
      end

      assign timer_out[c] = out_level;
      assign timer_out_en[c] = |{stat.out_sel_b, stat.out_sel_a};

      // ---- interrupt requests ----
      assign match_a_irq[c] = stat.match_a_flag & timer_control.match_a_irq_en;
      assign match_b_irq[c] = stat.match_b_flag & timer_control.match_b_irq_en;
      assign wrap_irq[c] = stat.wrap_flag & timer_control.wrap_irq_en;
   end

   // ----------------------------------------
   // converter start request
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start <= 1'b0;
      end else begin
         conv_start <= match_a_p[0] & g_ch[0].stat.conv_trigger_enable;
      end
   end

endmodule

// [hdl/tmr_pkg.sv]
package tmr_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 8;
   localparam int STOP_W = 16;

   // ----------------------------------------
   // register map, byte addresses
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CONST_A = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CONST_B = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STOP = 8'h40;
   localparam logic [ADDR_W-1:0] CH_OFS_MASK = 8'h1F;
   localparam int CH_SHIFT = 5;

   // ----------------------------------------
   // reset values and field positions
   // ----------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] STAT0_RST = 8'h00;
   localparam logic [7:0] STAT1_RST = 8'h10;
   localparam logic [7:0] CONST_RST = 8'hFF;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [STOP_W-1:0] STOP_RST = 16'h3FFF;
   localparam int HALT_BIT = 12;
   localparam int FLAG_B_BIT = 7;
   localparam int FLAG_A_BIT = 6;
   localparam int WRAP_BIT = 5;
   localparam int RSV_BIT = 4;

   // ----------------------------------------
   // clock select, clear select, output actions
   // ----------------------------------------
   localparam logic [2:0] CKS_OFF = 3'h0;
   localparam logic [2:0] CKS_DIV_FAST = 3'h1;
   localparam logic [2:0] CKS_DIV_MID = 3'h2;
   localparam logic [2:0] CKS_DIV_SLOW = 3'h3;
   localparam logic [2:0] CKS_CASCADE = 3'h4;
   localparam logic [2:0] CKS_EXT_RISE = 3'h5;
   localparam logic [2:0] CKS_EXT_FALL = 3'h6;
   localparam logic [2:0] CKS_EXT_BOTH = 3'h7;
   localparam int DIV_FAST_RATIO = 8;
   localparam int DIV_MID_RATIO = 64;
   localparam int DIV_SLOW_RATIO = 8192;
   localparam logic [1:0] CLR_NONE = 2'h0;
   localparam logic [1:0] CLR_MATCH_A = 2'h1;
   localparam logic [1:0] CLR_MATCH_B = 2'h2;
   localparam logic [1:0] CLR_EXT = 2'h3;
   localparam logic [1:0] OUT_KEEP = 2'h0;
   localparam logic [1:0] OUT_LOW = 2'h1;
   localparam logic [1:0] OUT_HIGH = 2'h2;
   localparam logic [1:0] OUT_TOGGLE = 2'h3;

   // ----------------------------------------
   // register layouts
   // ----------------------------------------
   typedef struct packed {
      logic match_b_irq_en;
      logic match_a_irq_en;
      logic wrap_irq_en;
      logic [1:0] clear_sel;
      logic [2:0] clk_sel;
   } tmr_ctrl_t;

   typedef struct packed {
      logic match_b_flag;
      logic match_a_flag;
      logic wrap_flag;
      logic conv_trigger_enable;
      logic [1:0] out_sel_b;
      logic [1:0] out_sel_a;
   } tmr_status_t;

endpackage

// [hdl/tmr_tick.sv]
`timescale 1ns/10ps
module tmr_tick #(
   parameter int PRESC_W = 13,
   parameter int FAST_BIT = 2,
   parameter int MID_BIT = 5,
   parameter int SLOW_BIT = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run,
   input wire logic [2:0] clk_sel,
   input wire logic [PRESC_W-1:0] presc,
   input wire logic ext_clk,
   input wire logic casc_pulse,
   output logic tick
);
   import tmr_pkg::*;

   logic level;
   logic level_prev;

   // ----------------------------------------
   // selected source level
   // ----------------------------------------
   always_comb begin
      unique case (clk_sel)
         CKS_DIV_FAST: level = presc[FAST_BIT];
         CKS_DIV_MID: level = presc[MID_BIT];
         CKS_DIV_SLOW: level = presc[SLOW_BIT];
         CKS_EXT_RISE, CKS_EXT_FALL, CKS_EXT_BOTH: level = ext_clk;
         default: level = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_prev <= 1'b0;
      end else begin
         level_prev <= level;
      end
   end

   // ----------------------------------------
   // edge to count pulse
   // ----------------------------------------
   always_comb begin
      unique case (clk_sel)
         CKS_DIV_FAST, CKS_DIV_MID, CKS_DIV_SLOW: tick = run & level_prev & ~level;
         CKS_EXT_RISE: tick = run & ~level_prev & level;
         CKS_EXT_FALL: tick = run & level_prev & ~level;
         CKS_EXT_BOTH: tick = run & (level_prev ^ level);
         CKS_CASCADE: tick = run & casc_pulse;
         default: tick = 1'b0;
      endcase
   end

endmodule

// [testbench/tmr_timer8_properties.sv]
`timescale 1ns/10ps
module tmr_timer8_checker
   import tmr_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [DATA_W-1:0] pwdata,
   input wire logic [DATA_W-1:0] prdata,
   input wire logic pslverr,
   input wire logic [NUM_CH-1:0] timer_out,
   input wire logic [NUM_CH-1:0] timer_out_en,
   input wire logic conv_start,
   input wire logic timer_halted
);
   // --------------------
   // bus and output checks
   // --------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic acc;
   assign acc = psel && penable;

   halt_refuse_a: assert property (acc && timer_halted && paddr != OFS_STOP |-> pslverr)
      else $error("halted access not refused");
   err_phase_a: assert property (pslverr |-> acc)
      else $error("error outside access phase");
   stop_write_a: assert property (acc && pwrite && paddr == OFS_STOP |=> timer_halted == $past(pwdata[HALT_BIT]))
      else $error("halt bit not taken");
   stop_reset_a: assert property ($rose(presetn) |-> timer_halted)
      else $error("timer not halted after reset");
   out_reset_a: assert property ($rose(presetn) |-> timer_out == 2'h0 && timer_out_en == 2'h0)
      else $error("output not low after reset");
   out_enable_a: assert property (acc && pwrite && !timer_halted && paddr == OFS_STAT
      |=> timer_out_en[0] == ($past(pwdata[3:0]) != 4'h0))
      else $error("output enable wrong");
   rsv_read_a: assert property (acc && !pwrite && !timer_halted && paddr == 8'h24
      |-> prdata[RSV_BIT] && prdata[31:8] == 24'h0)
      else $error("reserved bit not one");
   conv_pulse_a: assert property (conv_start |-> !timer_halted && !$past(conv_start))
      else $error("converter start not a single pulse");

   cover property (conv_start);
   cover property ($rose(timer_out[1]));
   cover property (pslverr);
endmodule

// [testbench/tmr_xfer_model.sv]
`timescale 1ns/10ps
module tmr_xfer_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic enable,
   input wire logic slow,
   input wire logic [1:0] irq_a,
   input wire logic [1:0] irq_b,
   output logic [1:0] start_a,
   output logic [1:0] start_b
);
   // --------------------
   // transfer start on request rise
   // --------------------
   logic [1:0] a1, a2, b1, b2;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a1 <= 2'h0;
         a2 <= 2'h0;
         b1 <= 2'h0;
         b2 <= 2'h0;
         start_a <= 2'h0;
         start_b <= 2'h0;
      end else begin
         a1 <= irq_a;
         a2 <= a1;
         b1 <= irq_b;
         b2 <= b1;
         start_a <= enable ? (slow ? a1 & ~a2 : irq_a & ~a1) : 2'h0;
         start_b <= enable ? (slow ? b1 & ~b2 : irq_b & ~b1) : 2'h0;
      end
   end
endmodule

// [testbench/tmr_timer8_test.sv]
`timescale 1ns/10ps
module tmr_timer8_test;
   import tmr_pkg::*;
   // --------------------
   // signals and instances
   // --------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, conv_start, timer_halted, rerr;
   logic dtc_on = 1'b0;
   logic slow = 1'b0;
   logic out1 = 1'b0;
   logic [1:0] ext = 2'h0;
   logic [1:0] sel = 2'h0;
   logic [1:0] xclr = 2'h0;
   logic [1:0] xa, xb, tout, toen, ia, ib, iw, osa, osb;
   logic [7:0] k;
   int errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 38287;

   always #12.5 pclk = ~pclk;

   tmr_timer8 #(.SLOW_DIV(128)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_in(ext), .ext_clear_in(xclr), .xfer_start_a(xa), .xfer_start_b(xb),
      .clear_on_transfer_select_a(sel), .clear_on_transfer_select_b(sel), .timer_out(tout),
      .timer_out_en(toen), .match_a_irq(ia), .match_b_irq(ib), .wrap_irq(iw), .conv_start(conv_start),
      .timer_halted(timer_halted));

   tmr_xfer_model XFER (.pclk(pclk), .presetn(presetn), .enable(dtc_on), .slow(slow), .irq_a(ia),
      .irq_b(ib), .start_a(xa), .start_b(xb));

   // --------------------
   // tasks
   // --------------------
   task give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         give_verdict();
      end
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      check(rdat, x);
      check(rerr, xe);
   endtask

   task wait_ev(input int which);
      int n;
      n = 0;
      while (n < 3000 && !(which == 0 ? conv_start === 1'b1 : ib[1] === 1'b1)) begin
         @(posedge pclk);
         n++;
      end
      if (n == 3000) begin
         errors++;
         $display("[FAIL] %0t awaited event missing", $time);
      end
   endtask

   task ext_pulse();
      repeat (4) @(posedge pclk);
      ext[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      ext[0] <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask

   function automatic logic nxt(input logic o, input logic [1:0] a, input logic [1:0] b);
      if (a == OUT_TOGGLE || b == OUT_TOGGLE) return ~o;
      if (a == OUT_HIGH || b == OUT_HIGH) return 1'b1;
      if (a == OUT_LOW || b == OUT_LOW) return 1'b0;
      return o;
   endfunction

   // --------------------
   // main sequence
   // --------------------
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check(timer_halted, 1'b1);
      rd(8'h04, 32'h0, 1'b1);
      rd(OFS_STOP, 32'h3FFF, 1'b0);
      wr(OFS_STOP, 32'h2FFF);
      check(timer_halted, 1'b0);
      rd(8'h04, 32'h0, 1'b0);
      rd(8'h24, 32'h10, 1'b0);
      wr(8'h24, 32'hEF);
      rd(8'h24, 32'h1F, 1'b0);
      wr(8'h24, 32'h0);
      rd(8'h24, 32'h10, 1'b0);
      check(tout, 2'h0);
      k = 8'h02 + {6'h0, 2'($random(seed))};
      wr(8'h08, {24'h0, k});
      wr(8'h0C, 32'h80);
      wr(8'h04, 32'h13);
      wr(8'h00, 32'h49);
      wait_ev(0);
      wr(8'h00, 32'h48);
      check(tout[0], 1'b1);
      check(ia[0], 1'b1);
      wr(8'h04, 32'h13);
      rd(8'h04, 32'h53, 1'b0);
      wr(8'h04, 32'h13);
      rd(8'h04, 32'h13, 1'b0);
      wr(8'h28, {24'h0, k});
      wr(8'h2C, {24'h0, k});
      for (int i = 0; i < 5; i++) begin
         osa = (i == 0) ? OUT_TOGGLE : 2'($random(seed));
         osb = (i == 0) ? OUT_TOGGLE : 2'($random(seed));
         wr(8'h24, {28'h0, osb, osa});
         wr(8'h30, 32'h0);
         wr(8'h20, 32'h91);
         wait_ev(1);
         wr(8'h20, 32'h90);
         out1 = nxt(out1, osa, osb);
         check(tout[1], out1);
         check(toen[1], |{osa, osb});
         check(ia[1], 1'b0);
         rd(8'h24, {24'h0, 4'hD, osb, osa}, 1'b0);
         wr(8'h24, {28'h0, osb, osa});
      end
      wr(8'h30, 32'h0);
      wr(8'h20, {29'h0, CKS_DIV_MID});
      repeat (3 * DIV_MID_RATIO - 2) @(posedge pclk);
      wr(8'h20, 32'h0);
      rd(8'h30, 32'h3, 1'b0);
      for (int m = 5; m < 8; m++) begin
         wr(8'h00, {24'h0, 5'h04, 3'(m)});
         wr(8'h10, 32'hFF);
         ext_pulse();
         rd(8'h10, (m == 7) ? 32'h1 : 32'h0, 1'b0);
         check(iw[0], 1'b1);
      end
      wr(8'h00, 32'h18);
      xclr[0] <= 1'b1;
      repeat (2) @(posedge pclk);
      xclr[0] <= 1'b0;
      rd(8'h10, 32'h0, 1'b0);
      wr(8'h00, 32'h20);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h20, 1'b0);
      wr(8'h04, 32'h0);
      rd(8'h04, 32'h0, 1'b0);
      check(iw[0], 1'b0);
      slow <= 1'b1;
      dtc_on <= 1'b1;
      wr(8'h04, 32'h10);
      wr(8'h00, 32'h49);
      wait_ev(0);
      wr(8'h00, 32'h48);
      rd(8'h04, 32'h10, 1'b0);
      check(tout[0], 1'b1);
      sel <= 2'h3;
      wr(8'h00, 32'h49);
      wait_ev(0);
      wr(8'h00, 32'h48);
      rd(8'h04, 32'h50, 1'b0);
      dtc_on <= 1'b0;
      rd(8'h50, 32'h0, 1'b1);
      wr(OFS_STOP, 32'h3FFF);
      check(timer_halted, 1'b1);
      rd(8'h24, 32'h0, 1'b1);
      give_verdict();
   end
endmodule

bind tmr_timer8 tmr_timer8_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr),
   .timer_out(timer_out), .timer_out_en(timer_out_en), .conv_start(conv_start), .timer_halted(timer_halted));
